/* logic/cmd_regs.svh */
// Address map, field positions and reset values of the memory decoder.
`ifndef CMD_REGS_SVH
`define CMD_REGS_SVH
// ************************************************************
// Program space
// ************************************************************
`define CMD_RESET_PC 16'h0000
`define CMD_PC_STEP 16'h0001
// ************************************************************
// Data space windows
// ************************************************************
`define CMD_IO_END 16'h1000
`define CMD_PORT_END 16'h0040
`define CMD_BITIO_END 16'h0020
`define CMD_NVM_BASE 16'h1000
`define CMD_NVM_END 16'h1800
`define CMD_SRAM_BASE 16'h3E00
`define CMD_SRAM_END 16'h4000
`define CMD_FLASH_BASE 16'h8000
// ************************************************************
// Register file and status flags
// ************************************************************
`define CMD_PTR_BASE 5'h1A
`define CMD_SREG_C 0
`define CMD_SREG_Z 1
`define CMD_SREG_N 2
`define CMD_SREG_V 3
`define CMD_SREG_S 4
`endif

/* logic/cmd_pkg.sv */
// Types shared by the memory space decoder modules.
package cmd_pkg;
    // Kind of data request issued by the core.
    typedef enum logic [1:0] {
        CMD_K_LDST,
        CMD_K_PORT,
        CMD_K_BIT,
        CMD_K_PML
    } cmd_kind_type;
    // State of the decoder top.
    typedef struct packed {
        logic [15:0] prog_addr;
        logic [15:0] pc;
        logic pf;
        logic pml;
        logic pml_odd;
        logic [15:0] instr;
        logic iv;
        logic io_sel;
        logic nvm_sel;
        logic sram_sel;
        logic fl_sel;
        logic we;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] wmask;
        logic rd;
        logic hi_tmp;
        logic cap_temp;
        logic bit_test;
        logic [2:0] bitn;
        logic [7:0] drd;
        logic dv;
        logic [4:0] sreg;
    } cmd_top_state_type;
    // State of the wide register staging byte.
    typedef struct packed {
        logic [7:0] temp;
    } cmd_pr_state_type;
    // State of the working register file.
    typedef struct packed {
        logic [31:0][7:0] mem;
        logic [7:0] da;
        logic [7:0] db;
    } cmd_rf_state_type;
endpackage : cmd_pkg

/* logic/cmd_link_if.sv */
// Interface joining the decoder top to its register file and staging byte.
`timescale 1ns/10ps
interface cmd_link_if;
    logic pr_lo_wr;
    logic [7:0] pr_lo_data;
    logic pr_cap;
    logic [7:0] pr_cap_data;
    logic [7:0] pr_temp;
    logic rf_we;
    logic [4:0] rf_widx;
    logic [7:0] rf_wdata;
    logic rf_pwe;
    logic [1:0] rf_psel;
    logic [15:0] rf_pdata;
    logic [4:0] rf_ra;
    logic [4:0] rf_rb;
    logic [7:0] rf_da;
    logic [7:0] rf_db;
    logic [2:0][15:0] rf_ptr;
    modport top(output pr_lo_wr, pr_lo_data, pr_cap, pr_cap_data,
                output rf_we, rf_widx, rf_wdata, rf_pwe, rf_psel,
                output rf_pdata, rf_ra, rf_rb,
                input pr_temp, rf_da, rf_db, rf_ptr);
    modport pr(input pr_lo_wr, pr_lo_data, pr_cap, pr_cap_data,
               output pr_temp);
    modport rf(input rf_we, rf_widx, rf_wdata, rf_pwe, rf_psel,
               input rf_pdata, rf_ra, rf_rb,
               output rf_da, rf_db, rf_ptr);
endinterface : cmd_link_if

/* logic/cmd_pair_temp.sv */
// Staging byte that pairs two byte accesses into one wide access.
`timescale 1ns/10ps
module cmd_pair_temp
    import cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    cmd_link_if.pr lk
);
    cmd_pr_state_type s;
    cmd_pr_state_type n;

    // A low byte write parks its data; a low byte read parks the high byte.
    always_comb begin
        n = s;
        if (lk.pr_lo_wr) begin
            n.temp = lk.pr_lo_data;
        end else if (lk.pr_cap) begin
            n.temp = lk.pr_cap_data;
        end
    end

    // State register.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign lk.pr_temp = s.temp;
endmodule : cmd_pair_temp

/* logic/cmd_regfile.sv */
// Working register file of 32 bytes with three 16-bit pointer pairs.
`timescale 1ns/10ps
`include "cmd_regs.svh"
module cmd_regfile
    import cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    cmd_link_if.rf lk
);
    cmd_rf_state_type s;
    cmd_rf_state_type n;
    logic [4:0] pbase;

    // Byte and pointer writes, and registered reads of two operands.
    always_comb begin
        n = s;
        pbase = 5'(`CMD_PTR_BASE + {2'b00, lk.rf_psel, 1'b0});
        n.da = s.mem[lk.rf_ra];
        n.db = s.mem[lk.rf_rb];
        if (lk.rf_we) begin
            n.mem[lk.rf_widx] = lk.rf_wdata;
        end
        if (lk.rf_pwe && lk.rf_psel != 2'h3) begin
            n.mem[pbase] = lk.rf_pdata[7:0];
            n.mem[5'(pbase + 5'h01)] = lk.rf_pdata[15:8];
        end
    end

    // State register.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Each pointer pair: low byte at the lower register index.
    for (genvar i = 0; i < 3; i++) begin : g_ptr
        assign lk.rf_ptr[i] = {s.mem[`CMD_PTR_BASE + 2 * i + 1],
                               s.mem[`CMD_PTR_BASE + 2 * i]};
    end
    assign lk.rf_da = s.da;
    assign lk.rf_db = s.db;
endmodule : cmd_regfile

/* logic/cmd_decoder.sv */
// Fetch pipeline, data space decoder and register file of the core.
`timescale 1ns/10ps
`include "cmd_regs.svh"
module cmd_decoder
    import cmd_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    output logic [15:0] prog_addr,
    input wire logic [15:0] prog_rdata,
    output logic [15:0] instr,
    output logic instr_valid,
    input wire logic fetch_hold,
    input wire logic jump_valid,
    input wire logic [15:0] jump_pc,
    input wire logic dreq_valid,
    input wire cmd_kind_type dreq_kind,
    input wire logic dreq_we,
    input wire logic dreq_wide,
    input wire logic dreq_use_ptr,
    input wire logic [1:0] dreq_ptr_sel,
    input wire logic [15:0] dreq_addr,
    input wire logic [2:0] dreq_bit,
    input wire logic dreq_bit_set,
    input wire logic [7:0] dreq_wdata,
    output logic [7:0] drd_data,
    output logic drd_valid,
    output logic io_sel,
    output logic nvm_sel,
    output logic sram_sel,
    output logic flash_sel,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [15:0] mem_wmask,
    input wire logic [15:0] io_rdata,
    input wire logic [7:0] nvm_rdata,
    input wire logic [7:0] sram_rdata,
    input wire logic [7:0] flash_rdata,
    input wire logic rf_wr_en,
    input wire logic [4:0] rf_wr_idx,
    input wire logic [7:0] rf_wr_data,
    input wire logic ptr_wr_en,
    input wire logic [1:0] ptr_sel,
    input wire logic [15:0] ptr_wr_data,
    input wire logic [4:0] rf_rd_a_idx,
    input wire logic [4:0] rf_rd_b_idx,
    output logic [7:0] rf_rd_a_data,
    output logic [7:0] rf_rd_b_data,
    input wire logic alu_valid,
    input wire logic [7:0] alu_result,
    input wire logic alu_carry,
    input wire logic alu_ovf,
    output logic [4:0] sreg
);
    cmd_top_state_type s;
    cmd_top_state_type n;
    logic [15:0] ea;
    logic [15:0] ptr;
    logic [1:0] psel;
    logic pml_go;
    logic data_go;

    cmd_link_if lk();

    // ************************************************************
    // Register file and wide register staging byte
    // ************************************************************
    cmd_regfile u_regfile (
        .core_clk(core_clk),
        .reset(reset),
        .lk(lk.rf)
    );

    cmd_pair_temp u_pair (
        .core_clk(core_clk),
        .reset(reset),
        .lk(lk.pr)
    );

    // Core side register file ports feed the file directly.
    assign lk.rf_we = rf_wr_en;
    assign lk.rf_widx = rf_wr_idx;
    assign lk.rf_wdata = rf_wr_data;
    assign lk.rf_pwe = ptr_wr_en;
    assign lk.rf_psel = ptr_sel;
    assign lk.rf_pdata = ptr_wr_data;
    assign lk.rf_ra = rf_rd_a_idx;
    assign lk.rf_rb = rf_rd_b_idx;
    assign lk.pr_lo_data = dreq_wdata;
    assign lk.pr_cap_data = io_rdata[15:8];

    // ************************************************************
    // Request classification
    // ************************************************************
    // Pointer select 3 has no pair and falls back to the third one.
    assign psel = (dreq_ptr_sel > 2'h2) ? 2'h2 : dreq_ptr_sel;
    assign ptr = lk.rf_ptr[psel];
    assign pml_go = dreq_valid && dreq_kind == CMD_K_PML;
    assign data_go = dreq_valid && dreq_kind != CMD_K_PML;

    // Effective data address; port and bit forms carry short addresses.
    always_comb begin
        ea = dreq_use_ptr ? 16'(ptr + dreq_addr) : dreq_addr;
        if (dreq_kind == CMD_K_PORT) begin
            ea = {10'h000, dreq_addr[5:0]};
        end else if (dreq_kind == CMD_K_BIT) begin
            ea = {11'h000, dreq_addr[4:0]};
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        n = s;
        n.io_sel = 1'b0;
        n.nvm_sel = 1'b0;
        n.sram_sel = 1'b0;
        n.fl_sel = 1'b0;
        n.rd = 1'b0;
        n.hi_tmp = 1'b0;
        n.cap_temp = 1'b0;
        n.bit_test = 1'b0;
        n.dv = 1'b0;
        n.pml = 1'b0;
        lk.pr_lo_wr = 1'b0;
        lk.pr_cap = 1'b0;
        // Capture the prefetched word unless the core holds its issue.
        if (!fetch_hold) begin
            n.instr = prog_rdata;
            n.iv = s.pf && !jump_valid;
        end
        // Program bus address: program load, jump, advance or hold.
        if (pml_go) begin
            n.prog_addr = {1'b0, lk.rf_ptr[2][15:1]};
            n.pml_odd = lk.rf_ptr[2][0];
            n.pml = 1'b1;
            n.pf = 1'b0;
            n.pc = (fetch_hold && s.pf) ? s.prog_addr : s.pc;
        end else if (jump_valid) begin
            n.prog_addr = jump_pc;
            n.pc = jump_pc + `CMD_PC_STEP;
            n.pf = 1'b1;
        end else if (!fetch_hold || !s.pf) begin
            n.prog_addr = s.pc;
            n.pc = s.pc + `CMD_PC_STEP;
            n.pf = 1'b1;
        end
        // Program load byte arrives one cycle after its address.
        if (s.pml) begin
            n.drd = s.pml_odd ? prog_rdata[15:8] : prog_rdata[7:0];
            n.dv = 1'b1;
        end
        // Data read answer one cycle after the target strobe.
        if (s.rd) begin
            n.dv = 1'b1;
            n.drd = 8'h00;
            if (s.hi_tmp) begin
                n.drd = lk.pr_temp;
            end else if (s.io_sel) begin
                n.drd = s.bit_test ? {7'h00, io_rdata[s.bitn]}
                                   : io_rdata[7:0];
                lk.pr_cap = s.cap_temp;
            end else if (s.nvm_sel) begin
                n.drd = nvm_rdata;
            end else if (s.sram_sel) begin
                n.drd = sram_rdata;
            end else if (s.fl_sel) begin
                n.drd = flash_rdata;
            end
        end
        // Data request decode, on its own bus beside the fetch.
        if (data_go) begin
            n.we = dreq_we;
            n.rd = !dreq_we;
            n.wdata = {8'h00, dreq_wdata};
            n.wmask = 16'h00FF;
            n.addr = ea;
            if (ea < `CMD_IO_END) begin
                // I/O space, reached by every form.
                if (dreq_kind == CMD_K_BIT) begin
                    n.io_sel = 1'b1;
                    n.wmask = {8'h00, 8'h01 << dreq_bit};
                    n.wdata = dreq_bit_set ? 16'h00FF : 16'h0000;
                    n.bit_test = !dreq_we;
                    n.bitn = dreq_bit;
                end else if (dreq_wide && !ea[0] && dreq_we) begin
                    lk.pr_lo_wr = 1'b1;
                end else if (dreq_wide && ea[0] && dreq_we) begin
                    n.io_sel = 1'b1;
                    n.addr = {ea[15:1], 1'b0};
                    n.wdata = {dreq_wdata, lk.pr_temp};
                    n.wmask = 16'hFFFF;
                end else if (dreq_wide && ea[0]) begin
                    n.hi_tmp = 1'b1;
                end else begin
                    n.io_sel = 1'b1;
                    n.cap_temp = dreq_wide;
                end
            end else if (ea < `CMD_NVM_END) begin
                n.nvm_sel = 1'b1;
                n.addr = ea - `CMD_NVM_BASE;
            end else if (ea >= `CMD_FLASH_BASE) begin
                n.fl_sel = 1'b1;
                n.addr = ea - `CMD_FLASH_BASE;
            end else if (ea >= `CMD_SRAM_BASE && ea < `CMD_SRAM_END) begin
                n.sram_sel = 1'b1;
                n.addr = ea - `CMD_SRAM_BASE;
            end
        end
        // Status flags reflect the most recent arithmetic result.
        if (alu_valid) begin
            n.sreg[`CMD_SREG_C] = alu_carry;
            n.sreg[`CMD_SREG_Z] = alu_result == 8'h00;
            n.sreg[`CMD_SREG_N] = alu_result[7];
            n.sreg[`CMD_SREG_V] = alu_ovf;
            n.sreg[`CMD_SREG_S] = alu_result[7] ^ alu_ovf;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // Fetch restarts at the reset vector with the first word on the bus.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s <= '0;
            s.prog_addr <= `CMD_RESET_PC;
            s.pc <= `CMD_RESET_PC + `CMD_PC_STEP;
            s.pf <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs come straight from the state register.
    assign prog_addr = s.prog_addr;
    assign instr = s.instr;
    assign instr_valid = s.iv;
    assign drd_data = s.drd;
    assign drd_valid = s.dv;
    assign io_sel = s.io_sel;
    assign nvm_sel = s.nvm_sel;
    assign sram_sel = s.sram_sel;
    assign flash_sel = s.fl_sel;
    assign mem_we = s.we;
    assign mem_addr = s.addr;
    assign mem_wdata = s.wdata;
    assign mem_wmask = s.wmask;
    assign sreg = s.sreg;
    assign rf_rd_a_data = lk.rf_da;
    assign rf_rd_b_data = lk.rf_db;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // A data access does not stall the sequential fetch.
    property p_fetch_beside_data;
        data_go && s.pf && !fetch_hold && !jump_valid
            |=> prog_addr == $past(s.pc) && mem_we == $past(dreq_we);
    endproperty
    a_fetch_beside_data: assert property (p_fetch_beside_data)
        else $error("Fetch stalled by a data access.");

    // The word on the program bus becomes the next instruction.
    property p_prefetch;
        s.pf && !fetch_hold && !jump_valid
            |=> instr_valid && instr == $past(prog_rdata);
    endproperty
    a_prefetch: assert property (p_prefetch)
        else $error("Prefetched word not issued.");

    // First address after reset is the reset vector.
    property p_reset_pc;
        $fell(reset) |-> prog_addr == `CMD_RESET_PC;
    endproperty
    a_reset_pc: assert property (p_reset_pc)
        else $error("First fetch not at word zero.");

    // Direct loads below 4KB strobe the I/O space.
    property p_io_window;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr
            && !dreq_wide && dreq_addr < `CMD_IO_END
            |=> io_sel && mem_addr == $past(dreq_addr);
    endproperty
    a_io_window: assert property (p_io_window)
        else $error("Low address not decoded to I/O.");

    // Port forms use only the six low address bits.
    property p_port_form;
        data_go && dreq_kind == CMD_K_PORT && !dreq_wide
            |=> io_sel && mem_addr == {10'h000, $past(dreq_addr[5:0])};
    endproperty
    a_port_form: assert property (p_port_form)
        else $error("Port form address wrong.");

    // Bit forms touch one bit below address 32.
    property p_bit_form;
        data_go && dreq_kind == CMD_K_BIT
            |=> io_sel && mem_addr < `CMD_BITIO_END
                && $onehot(mem_wmask) && mem_wmask[15:8] == 8'h00;
    endproperty
    a_bit_form: assert property (p_bit_form)
        else $error("Bit form outside its window.");

    // Fuse and NVM window with its offset removed.
    property p_nvm_window;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr
            && dreq_addr >= `CMD_NVM_BASE && dreq_addr < `CMD_NVM_END
            |=> nvm_sel && !io_sel
                && mem_addr == $past(dreq_addr) - `CMD_NVM_BASE;
    endproperty
    a_nvm_window: assert property (p_nvm_window)
        else $error("NVM window decode wrong.");

    // SRAM window inside the other memories region.
    property p_sram_window;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr
            && dreq_addr >= `CMD_SRAM_BASE && dreq_addr < `CMD_SRAM_END
            |=> sram_sel && mem_addr == $past(dreq_addr) - `CMD_SRAM_BASE;
    endproperty
    a_sram_window: assert property (p_sram_window)
        else $error("SRAM window decode wrong.");

    // Upper half of data space reads Flash.
    property p_flash_window;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr
            && dreq_addr >= `CMD_FLASH_BASE
            |=> flash_sel && !sram_sel
                && mem_addr == $past(dreq_addr) - `CMD_FLASH_BASE;
    endproperty
    a_flash_window: assert property (p_flash_window)
        else $error("Flash window decode wrong.");

    // Program load presents the pointer as a code space word address.
    property p_prog_load;
        pml_go |=> prog_addr == {1'b0, $past(lk.rf_ptr[2][15:1])}
                   ##1 drd_valid;
    endproperty
    a_prog_load: assert property (p_prog_load)
        else $error("Program load addressing wrong.");

    // Zero and sign flags follow the result.
    property p_flags;
        alu_valid |=> sreg[`CMD_SREG_Z] == ($past(alu_result) == 8'h00)
            && sreg[`CMD_SREG_S] == ($past(alu_result[7]) ^ $past(alu_ovf));
    endproperty
    a_flags: assert property (p_flags)
        else $error("Status flags do not match result.");

    // High byte read of a wide register comes from the staging byte.
    property p_wide_high;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr && dreq_wide
            && !dreq_we && dreq_addr[0] && dreq_addr < `CMD_IO_END
            |=> !io_sel ##1 drd_valid && drd_data == $past(lk.pr_temp);
    endproperty
    a_wide_high: assert property (p_wide_high)
        else $error("Wide high byte not from staging byte.");

    // Unmapped reads answer zero with no strobe.
    property p_unmapped;
        data_go && dreq_kind == CMD_K_LDST && !dreq_use_ptr && !dreq_we
            && dreq_addr >= `CMD_NVM_END && dreq_addr < `CMD_SRAM_BASE
            |=> !(io_sel || nvm_sel || sram_sel || flash_sel)
                ##1 drd_valid && drd_data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Unmapped read not zero.");
endmodule : cmd_decoder

/* logic/cmd_decoder_unused.sv */
// Spare file of the memory decoder; it holds no logic.

/* test/cmd_mem_model.sv */
// Memory and peripheral model answering the decoder's buses.
`timescale 1ns/10ps
module cmd_mem_model (
    input wire logic [15:0] prog_addr,
    input wire logic [15:0] mem_addr,
    input wire logic io_sel,
    input wire logic nvm_sel,
    input wire logic sram_sel,
    input wire logic flash_sel,
    output logic [15:0] prog_rdata,
    output logic [15:0] io_rdata,
    output logic [7:0] nvm_rdata,
    output logic [7:0] sram_rdata,
    output logic [7:0] flash_rdata
);
    // Unselected targets show inverted data, so no stale byte looks valid.
    always_comb begin
        prog_rdata = {prog_addr[7:0] ^ 8'hA5, prog_addr[7:0]};
        io_rdata = {mem_addr[7:0] + 8'h01, mem_addr[7:0]};
        nvm_rdata = mem_addr[7:0] ^ 8'h5A;
        sram_rdata = mem_addr[7:0] ^ 8'h3C;
        flash_rdata = mem_addr[7:0] ^ 8'hC3;
        io_rdata = io_sel ? io_rdata : ~io_rdata;
        nvm_rdata = nvm_sel ? nvm_rdata : ~nvm_rdata;
        sram_rdata = sram_sel ? sram_rdata : ~sram_rdata;
        flash_rdata = flash_sel ? flash_rdata : ~flash_rdata;
    end
endmodule : cmd_mem_model

/* test/tb_top.sv */
// Self-checking bench of the memory space decoder.
`timescale 1ns/10ps
module tb_top;
    import cmd_pkg::*;
    logic core_clk, reset, fetch_hold, jump_valid, dreq_valid, dreq_we;
    logic dreq_wide, dreq_use_ptr, dreq_bit_set, rf_wr_en, ptr_wr_en;
    logic alu_valid, alu_carry, alu_ovf, instr_valid, drd_valid, mem_we;
    logic io_sel, nvm_sel, sram_sel, flash_sel;
    logic [15:0] prog_addr, prog_rdata, instr, jump_pc, dreq_addr;
    logic [15:0] mem_addr, mem_wdata, mem_wmask, io_rdata, ptr_wr_data;
    logic [7:0] dreq_wdata, drd_data, nvm_rdata, sram_rdata, flash_rdata;
    logic [7:0] rf_wr_data, rf_rd_a_data, rf_rd_b_data, alu_result;
    logic [4:0] rf_wr_idx, rf_rd_a_idx, rf_rd_b_idx, sreg;
    logic [2:0] dreq_bit;
    logic [1:0] dreq_ptr_sel, ptr_sel;
    cmd_kind_type dreq_kind;
    int error_cnt = 0;
    int n_compared = 0;
    logic [3:0] s;
    logic [15:0] ma, rd;

    cmd_decoder cmd_decoder_i (.*);
    cmd_mem_model cmd_mem_model_i (.*);

    // Free-running core clock of 10 ns.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : chk

    // One data request; strobes after one edge, answer after two.
    task automatic req(input cmd_kind_type k, input logic w, input logic wd,
                       input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        dreq_valid <= 1'b1;
        dreq_kind <= k;
        dreq_we <= w;
        dreq_wide <= wd;
        dreq_addr <= a;
        dreq_wdata <= d;
        @(posedge core_clk);
        dreq_valid <= 1'b0;
        #1;
        s = {io_sel, nvm_sel, sram_sel, flash_sel};
        ma = mem_addr;
        @(posedge core_clk);
        #1;
        rd = {7'h00, drd_valid, drd_data};
    endtask : req

    task automatic t_map;
        logic [15:0] a [9] = '{16'h0005, 16'h0FFF, 16'h1000, 16'h17FF,
            16'h1800, 16'h3E05, 16'h4000, 16'h8000, 16'hFFFF};
        logic [3:0] es [9] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'h0, 4'h2, 4'h0,
            4'h1, 4'h1};
        logic [15:0] eo [9] = '{16'h0005, 16'h0FFF, 16'h0000, 16'h07FF,
            16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h7FFF};
        logic [7:0] x [4] = '{8'hC3, 8'h3C, 8'h5A, 8'h00};
        for (int i = 0; i < 9; i++) begin
            req(CMD_K_LDST, 1'b0, 1'b0, a[i], 8'h00);
            chk(s, es[i]);
            if (es[i] != 4'h0) chk(ma, eo[i]);
            chk(rd, es[i] == 4'h0 ? 16'h0100 :
                {8'h01, es[i] == 4'h8 ? eo[i][7:0] :
                 eo[i][7:0] ^ x[$clog2(es[i])]});
        end
        req(CMD_K_LDST, 1'b1, 1'b0, 16'h4000, 8'h11);
        chk(s, 4'h0);
    endtask : t_map

    task automatic t_io;
        req(CMD_K_PORT, 1'b0, 1'b0, 16'h003F, 8'h00);
        chk({s, ma}, 20'h8003F);
        req(CMD_K_PORT, 1'b0, 1'b0, 16'h0045, 8'h00);
        chk({s, ma}, 20'h80005);
        dreq_bit <= 3'h3;
        dreq_bit_set <= 1'b1;
        req(CMD_K_BIT, 1'b1, 1'b0, 16'h0005, 8'h00);
        chk(mem_wmask, 16'h0008);
        chk(mem_wdata, 16'h00FF);
        chk(mem_we, 1'b1);
        dreq_bit <= 3'h2;
        req(CMD_K_BIT, 1'b0, 1'b0, 16'h0005, 8'h00);
        chk(rd, 16'h0101);
        req(CMD_K_LDST, 1'b0, 1'b1, 16'h0010, 8'h00);
        req(CMD_K_LDST, 1'b0, 1'b1, 16'h0011, 8'h00);
        chk({s, rd}, 20'h00111);
        req(CMD_K_LDST, 1'b1, 1'b1, 16'h0020, 8'hAA);
        chk(s, 4'h0);
        req(CMD_K_LDST, 1'b1, 1'b1, 16'h0021, 8'hBB);
        chk({s, ma}, 20'h80020);
        chk(mem_wdata, 16'hBBAA);
        chk(mem_wmask, 16'hFFFF);
    endtask : t_io

    task automatic t_regs;
        @(posedge core_clk);
        ptr_wr_en <= 1'b1;
        ptr_wr_data <= 16'h0009;
        rf_wr_en <= 1'b1;
        @(posedge core_clk);
        ptr_wr_en <= 1'b0;
        rf_wr_en <= 1'b0;
        @(posedge core_clk);
        #1;
        chk({rf_rd_a_data, rf_rd_b_data}, 16'h3C00);
        req(CMD_K_PML, 1'b0, 1'b0, 16'h0000, 8'h00);
        chk(rd, 16'h01A1);
        chk(instr_valid, 1'b0);
        dreq_use_ptr <= 1'b1;
        dreq_ptr_sel <= 2'h2;
        req(CMD_K_LDST, 1'b0, 1'b0, 16'h3DFC, 8'h00);
        dreq_use_ptr <= 1'b0;
        chk({s, ma}, 20'h20005);
        chk(rd, 16'h0139);
        @(posedge core_clk);
        alu_valid <= 1'b1;
        @(posedge core_clk);
        alu_result <= 8'h80;
        alu_carry <= 1'b0;
        #1;
        chk(sreg, 16'h0003);
        @(posedge core_clk);
        alu_valid <= 1'b0;
        #1;
        chk(sreg, 16'h0014);
    endtask : t_regs

    task automatic report_and_stop;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    // Inputs settle at time zero, reset runs, then the scenarios.
    initial begin
        {reset, alu_carry} = 2'h3;
        {fetch_hold, jump_valid, dreq_valid, dreq_we, dreq_wide} = 5'h00;
        {dreq_use_ptr, dreq_bit_set, rf_wr_en, ptr_wr_en} = 4'h0;
        {alu_valid, alu_ovf, alu_result, dreq_bit} = 13'h0000;
        {jump_pc, dreq_addr, dreq_wdata, dreq_ptr_sel} = 42'h0;
        {ptr_sel, ptr_wr_data, rf_wr_data} = {2'h2, 16'h0000, 8'h3C};
        {rf_wr_idx, rf_rd_a_idx, rf_rd_b_idx} = {5'h05, 5'h05, 5'h1F};
        dreq_kind = CMD_K_LDST;
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        chk(instr, 16'hA500);
        chk(prog_addr, 16'h0001);
        @(posedge core_clk);
        #1;
        chk({instr_valid, instr}, 17'h1A401);
        @(posedge core_clk);
        jump_pc <= 16'h0040;
        jump_valid <= 1'b1;
        @(posedge core_clk);
        jump_valid <= 1'b0;
        #1;
        chk({instr_valid, prog_addr}, 17'h00040);
        @(posedge core_clk);
        fetch_hold <= 1'b1;
        #1;
        chk({instr_valid, instr}, 17'h1E540);
        repeat (2) @(posedge core_clk);
        fetch_hold <= 1'b0;
        #1;
        chk(prog_addr, 16'h0041);
        chk(instr, 16'hE540);
        t_map();
        t_io();
        t_regs();
        report_and_stop();
    end
endmodule : tb_top
